// ==== rtl/dspt_pkg.sv ====
// Package: register map, field layout, modes and carriers for the dual-slope PWM timer
`default_nettype none
package dspt_pkg;
    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [5:0] ADDR_CTRL_A = 6'h00;
    localparam logic [5:0] ADDR_CTRL_B = 6'h04;
    localparam logic [5:0] ADDR_COUNT = 6'h08;
    localparam logic [5:0] ADDR_CMP_A = 6'h0c;
    localparam logic [5:0] ADDR_CMP_B = 6'h10;
    // ==========================================
    // Word indices (address bits 5:2)
    localparam logic [3:0] IDX_CTRL_A = 4'h0;
    localparam logic [3:0] IDX_CTRL_B = 4'h1;
    localparam logic [3:0] IDX_COUNT = 4'h2;
    localparam logic [3:0] IDX_CMP_A = 4'h3;
    localparam logic [3:0] IDX_CMP_B = 4'h4;
    localparam logic [3:0] IDX_CAPTURE = 4'h5;
    localparam logic [3:0] IDX_FLAGS = 4'h6;
    localparam logic [3:0] IDX_PINDIR = 4'h7;
    // ==========================================
    // Control A fields
    localparam int CA_COM_A_LSB = 6;
    localparam int CA_COM_B_LSB = 4;
    localparam int CA_FORCE_A = 3;
    localparam int CA_FORCE_B = 2;
    localparam int CA_WAVE_LSB = 0;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_A_RD_MASK = 8'hf3;
    // Control B: waveform mode high bits 1:0, prescaler select 4:2
    localparam int CB_WAVE_HI_LSB = 0;
    localparam int CB_PRESC_LSB = 2;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    // Flag register bits, write one to clear
    localparam int FL_OVF = 0;
    localparam int FL_CMP_A = 1;
    localparam int FL_CMP_B = 2;
    localparam int FL_CAPT = 3;
    // ==========================================
    // Waveform modes, output modes, counter limits
    localparam logic [3:0] WAVE_PC_ICR = 4'ha;
    localparam logic [3:0] WAVE_PC_CMPA = 4'hb;
    localparam logic [3:0] WAVE_PFC_ICR = 4'h8;
    localparam logic [3:0] WAVE_PFC_CMPA = 4'h9;
    localparam logic [3:0] WAVE_FAST_TGL = 4'he;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] TOP_RESET = 16'h0000;
    // Prescale dividers 1, 8, 64, 256, 1024
    localparam logic [9:0] DIV_1 = 10'h000;
    localparam logic [9:0] DIV_8 = 10'h007;
    localparam logic [9:0] DIV_64 = 10'h03f;
    localparam logic [9:0] DIV_256 = 10'h0ff;
    localparam logic [9:0] DIV_1024 = 10'h3ff;
    // ==========================================
    // Carrier: one channel's settings for the waveform unit
    typedef struct packed {
        logic [1:0] out_mode;
        logic [15:0] compare;
    } dspt_chan_t;
endpackage
`default_nettype wire

// ==== rtl/dspt_tick.sv ====
// Prescaler: one-cycle timer tick every N I/O clocks
`default_nettype none
module dspt_tick (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [9:0] cnt_q;
    logic [9:0] lim;

    // Select terminal count, divider 1 to 1024; sel 0 stops the timer
    always_comb begin
        case (sel)
            3'h1: lim = dspt_pkg::DIV_1;
            3'h2: lim = dspt_pkg::DIV_8;
            3'h3: lim = dspt_pkg::DIV_64;
            3'h4: lim = dspt_pkg::DIV_256;
            3'h5: lim = dspt_pkg::DIV_1024;
            default: lim = dspt_pkg::DIV_1;
        endcase
    end

    // Tick is a qualifier, never a clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 10'h000;
        end else if (ce) begin
            if (sel == 3'h0 || cnt_q >= lim) begin
                cnt_q <= 10'h000;
            end else begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end
    assign tick = ce && sel != 3'h0 && sel <= 3'h5 && cnt_q >= lim;
endmodule
`default_nettype wire

// ==== rtl/dspt_timer.sv ====
// Dual-slope 16-bit PWM timer with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`default_nettype none
module dspt_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic chan_a_wave_output,
    output logic chan_a_wave_oe,
    output logic chan_b_wave_output,
    output logic chan_b_wave_oe,
    output logic [1:0] port_release
);
    // ==========================================
    // Reset synchroniser
    logic rst_s1_q, rst_s2_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_i_n = rst_s2_q;

    // Every check below runs on the system clock and rests during reset
    default clocking dspt_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_i_n);

    // ==========================================
    // Registers
    logic [7:0] ctrl_a_q, ctrl_b_q;
    logic [15:0] count_q, cmp_a_buf_q, cmp_b_buf_q, cmp_a_q, cmp_b_q, capture_top_value_q;
    logic [3:0] flags_q;
    logic [1:0] pin_dir_q;
    logic up_q;
    logic wait_q;
    logic [31:0] rdata_q;

    wire logic [3:0] waveform_mode = {ctrl_b_q[dspt_pkg::CB_WAVE_HI_LSB +: 2],
                                     ctrl_a_q[dspt_pkg::CA_WAVE_LSB +: 2]};
    wire logic [3:0] idx = avs_address[5:2];
    wire logic wr = avs_write && !wait_q && avs_byteenable[0];
    wire logic tick;

    // ==========================================
    // Mode decode
    wire logic pfc = waveform_mode == dspt_pkg::WAVE_PFC_ICR
        || waveform_mode == dspt_pkg::WAVE_PFC_CMPA;
    wire logic pc = waveform_mode == dspt_pkg::WAVE_PC_ICR
        || waveform_mode == dspt_pkg::WAVE_PC_CMPA;
    wire logic dual = pfc || pc;
    wire logic top_is_a = waveform_mode == dspt_pkg::WAVE_PFC_CMPA
        || waveform_mode == dspt_pkg::WAVE_PC_CMPA;
    // TOP from channel A compare or capture register
    wire logic [15:0] top = top_is_a ? cmp_a_q : capture_top_value_q;
    wire logic at_top = count_q == top;
    wire logic at_bottom = count_q == dspt_pkg::CNT_BOTTOM;
    wire logic step = ce && tick && dual;
    // Compare load point: BOTTOM in frequency correct, TOP in phase correct
    wire logic load_pt = step && (pfc ? at_bottom : at_top);

    // ==========================================
    // Prescaler
    dspt_tick u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_i_n),
        .ce(ce),
        .sel(ctrl_b_q[dspt_pkg::CB_PRESC_LSB +: 3]),
        .tick(tick)
    );

    // ==========================================
    // Avalon slave: one wait cycle, then answer
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            wait_q <= 1'b1;
        end else if (ce) begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end
    assign avs_waitrequest = wait_q;

    // Read mux; registered so data is ready when waitrequest drops
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce && avs_read && wait_q) begin
            case (idx)
                dspt_pkg::IDX_CTRL_A: begin
                    rdata_q <= {24'h0, ctrl_a_q & dspt_pkg::CTRL_A_RD_MASK};
                end
                dspt_pkg::IDX_CTRL_B: rdata_q <= {24'h0, ctrl_b_q};
                dspt_pkg::IDX_COUNT: rdata_q <= {16'h0, count_q};
                dspt_pkg::IDX_CMP_A: rdata_q <= {16'h0, cmp_a_buf_q};
                dspt_pkg::IDX_CMP_B: rdata_q <= {16'h0, cmp_b_buf_q};
                dspt_pkg::IDX_CAPTURE: rdata_q <= {16'h0, capture_top_value_q};
                dspt_pkg::IDX_FLAGS: rdata_q <= {28'h0, flags_q};
                dspt_pkg::IDX_PINDIR: rdata_q <= {30'h0, pin_dir_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    // Control registers; strobe bits are not stored
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ctrl_a_q <= dspt_pkg::CTRL_A_RESET;
            ctrl_b_q <= dspt_pkg::CTRL_B_RESET;
            pin_dir_q <= 2'h0;
        end else if (ce && wr) begin
            if (idx == dspt_pkg::IDX_CTRL_A) begin
                ctrl_a_q <= avs_writedata[7:0] & dspt_pkg::CTRL_A_RD_MASK;
            end
            if (idx == dspt_pkg::IDX_CTRL_B) ctrl_b_q <= avs_writedata[7:0];
            if (idx == dspt_pkg::IDX_PINDIR) pin_dir_q <= avs_writedata[1:0];
        end
    end

    // Buffered compare writes and the unbuffered capture TOP
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cmp_a_buf_q <= dspt_pkg::CMP_RESET;
            cmp_b_buf_q <= dspt_pkg::CMP_RESET;
            capture_top_value_q <= dspt_pkg::TOP_RESET;
        end else if (ce && wr) begin
            if (idx == dspt_pkg::IDX_CMP_A) cmp_a_buf_q <= avs_writedata[15:0];
            if (idx == dspt_pkg::IDX_CMP_B) cmp_b_buf_q <= avs_writedata[15:0];
            if (idx == dspt_pkg::IDX_CAPTURE) capture_top_value_q <= avs_writedata[15:0];
        end
    end

    // Active compares load only at the update point; outside the dual-slope modes they follow at once
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cmp_a_q <= dspt_pkg::CMP_RESET;
            cmp_b_q <= dspt_pkg::CMP_RESET;
        end else if (ce && (load_pt || !dual)) begin
            cmp_a_q <= cmp_a_buf_q;
            cmp_b_q <= cmp_b_buf_q;
        end
    end

    // ==========================================
    // Up/down counter; TOP held one tick, then reversal
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            count_q <= dspt_pkg::CNT_BOTTOM;
            up_q <= 1'b1;
        end else if (ce && wr && idx == dspt_pkg::IDX_COUNT) begin
            count_q <= avs_writedata[15:0];
        end else if (step) begin
            if (up_q) begin
                if (at_top) begin
                    up_q <= 1'b0;
                    count_q <= count_q - 16'h0001;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end else if (at_bottom) begin
                up_q <= 1'b1;
                count_q <= count_q + 16'h0001;
            end else begin
                count_q <= count_q - 16'h0001;
            end
        end
    end

    // ==========================================
    // Flags: hardware set wins over write-one-to-clear
    wire logic match_a = count_q == cmp_a_q;
    wire logic match_b = count_q == cmp_b_q;
    logic [3:0] set_v;
    always_comb begin
        set_v = 4'h0;
        set_v[dspt_pkg::FL_OVF] = step && at_bottom;
        set_v[dspt_pkg::FL_CMP_A] = step && match_a;
        set_v[dspt_pkg::FL_CMP_B] = step && match_b;
        set_v[dspt_pkg::FL_CAPT] = step && !top_is_a && at_top;
    end
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            flags_q <= 4'h0;
        end else if (ce) begin
            if (wr && idx == dspt_pkg::IDX_FLAGS) begin
                flags_q <= (flags_q & ~avs_writedata[3:0]) | set_v;
            end else begin
                flags_q <= flags_q | set_v;
            end
        end
    end

    // ==========================================
    // Waveform units. Non-inverting match at the turn points yields BOTTOM low and TOP high
    // Toggle on A in modes 9 and 11, in 11 as the phase correct rule asks; mode 14 sets tgl_a but A never toggles there, as dual is low
    wire logic tgl_a = waveform_mode == dspt_pkg::WAVE_PFC_CMPA
        || waveform_mode == dspt_pkg::WAVE_FAST_TGL
        || waveform_mode == dspt_pkg::WAVE_PC_CMPA;
    dspt_pkg::dspt_chan_t ch_a, ch_b;
    assign ch_a = '{out_mode: ctrl_a_q[dspt_pkg::CA_COM_A_LSB +: 2], compare: cmp_a_q};
    assign ch_b = '{out_mode: ctrl_a_q[dspt_pkg::CA_COM_B_LSB +: 2], compare: cmp_b_q};
    logic wave_a, wave_b;
    // BOTTOM counts as rising and TOP as falling, so extreme compares hold a level
    // Toggle for A uses TOP match; B never toggles
    dspt_wave u_wave_a (
        .clk_sys(clk_sys),
        .rst_n(rst_i_n),
        .ce(ce),
        .tick(tick),
        .dual(dual),
        .tgl_ok(tgl_a),
        .up((up_q || at_bottom) && !at_top),
        .match(match_a),
        .chan(ch_a),
        .wave(wave_a)
    );
    dspt_wave u_wave_b (
        .clk_sys(clk_sys),
        .rst_n(rst_i_n),
        .ce(ce),
        .tick(tick),
        .dual(dual),
        .tgl_ok(1'b0),
        .up((up_q || at_bottom) && !at_top),
        .match(match_b),
        .chan(ch_b),
        .wave(wave_b)
    );

    // ==========================================
    // Pin stage: registered; drive only with direction set and a connected mode
    logic conn_a, conn_b;
    always_comb begin
        conn_a = ch_a.out_mode[1] || (ch_a.out_mode == dspt_pkg::COM_TOGGLE && tgl_a);
        conn_b = ch_b.out_mode[1];
    end
    always_ff @(posedge clk_sys or negedge rst_i_n) begin
        if (!rst_i_n) begin
            chan_a_wave_output <= 1'b0;
            chan_b_wave_output <= 1'b0;
            chan_a_wave_oe <= 1'b0;
            chan_b_wave_oe <= 1'b0;
            port_release <= 2'h3;
        end else if (ce) begin
            chan_a_wave_output <= wave_a;
            chan_b_wave_output <= wave_b;
            chan_a_wave_oe <= conn_a && pin_dir_q[0];
            chan_b_wave_oe <= conn_b && pin_dir_q[1];
            port_release <= {!conn_b, !conn_a};
        end
    end

    // ==========================================
    // Checks; the counter turn points are written as named sequences

    // Up step taken while the counter sits at TOP
    sequence s_top_step;
        step && up_q && at_top && !wr;
    endsequence

    // Down step taken while the counter sits at BOTTOM
    sequence s_bottom_step;
        step && !up_q && at_bottom && !wr;
    endsequence

    // Overflow flag follows every BOTTOM tick; a same-cycle clear must lose
    property p_flag_ovf;
        step && at_bottom |=> flags_q[dspt_pkg::FL_OVF];
    endproperty
    a_flag_ovf: assert property (p_flag_ovf) else $error("overflow flag missed");

    // Channel A flag follows every match
    property p_flag_cmp;
        step && match_a |=> flags_q[dspt_pkg::FL_CMP_A];
    endproperty
    a_flag_cmp: assert property (p_flag_cmp) else $error("compare flag missed");

    // Frequency correct modes move the active compare only at BOTTOM
    property p_load;
        pfc && !load_pt |=> $stable(cmp_a_q);
    endproperty
    a_load: assert property (p_load) else $error("compare loaded off BOTTOM");

    // TOP lasts one tick, then the count runs down
    property p_turn;
        s_top_step |=> !up_q && count_q == $past(count_q) - 16'h0001;
    endproperty
    a_turn: assert property (p_turn) else $error("no reversal at TOP");

    // BOTTOM lasts one tick, then the count runs up again
    property p_rebound;
        s_bottom_step |=> up_q && count_q == 16'h0001;
    endproperty
    a_rebound: assert property (p_rebound) else $error("no reversal at BOTTOM");

    // Non-inverted A clears on a match while counting up
    property p_wave_clr;
        step && match_a && up_q && !at_top
            && ch_a.out_mode == dspt_pkg::COM_NONINV |=> !wave_a;
    endproperty
    a_wave_clr: assert property (p_wave_clr) else $error("no clear on rising match");

    // Non-inverted A sets on a match while counting down
    property p_wave_set;
        step && match_a && !up_q && !at_bottom
            && ch_a.out_mode == dspt_pkg::COM_NONINV |=> wave_a;
    endproperty
    a_wave_set: assert property (p_wave_set) else $error("no set on falling match");

    // Driven pin A always has its direction bit behind it
    property p_oe;
        chan_a_wave_oe |-> $past(pin_dir_q[0]);
    endproperty
    a_oe: assert property (p_oe) else $error("pin driven without direction");
endmodule
`default_nettype wire

// ==== rtl/dspt_wave.sv ====
// Waveform unit for one channel in dual-slope PWM
`default_nettype none
module dspt_wave (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tick,
    input wire logic dual,
    input wire logic tgl_ok,
    input wire logic up,
    input wire logic match,
    input wire dspt_pkg::dspt_chan_t chan,
    output logic wave
);
    logic wave_q;

    // Clear on up-match and set on down-match, swapped when inverting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
        end else if (ce && tick && dual && match) begin
            case (chan.out_mode)
                dspt_pkg::COM_NONINV: wave_q <= !up;
                dspt_pkg::COM_INV: wave_q <= up;
                dspt_pkg::COM_TOGGLE: wave_q <= tgl_ok ? !wave_q : wave_q;
                default: wave_q <= wave_q;
            endcase
        end
    end
    assign wave = wave_q;
endmodule
`default_nettype wire

// ==== verif/dspt_pin_model.sv ====
// Port pin model: resolves both waveform pins against their output enables
`default_nettype none
module dspt_pin_model (
    input wire logic chan_a_wave_output,
    input wire logic chan_a_wave_oe,
    input wire logic chan_b_wave_output,
    input wire logic chan_b_wave_oe,
    output logic pin_a,
    output logic pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Pin levels
    // A released pin floats to its pull-up, so a stale waveform value never shows
    assign pin_a = chan_a_wave_oe ? chan_a_wave_output : 1'b1;
    assign pin_b = chan_b_wave_oe ? chan_b_wave_output : 1'b1;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Testbench: register access, waveform timing and pin control of the PWM timer
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [3:0] wave;
        logic [2:0] sel;
        logic [15:0] top;
        logic [15:0] cmp;
        logic [1:0] com;
        int hi;
        int per;
        logic [3:0] flags;
    } dspt_row_t;
    logic clk_sys, rst_n, ce, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d, d2;
    logic [3:0] avs_byteenable;
    logic wa, oa, wb, ob, pin_a, pin_b;
    logic [1:0] port_release;
    int n_fail, n_checks, cyc, t0, hi, lo, lo2, bad;
    // ==========================================
    // Cases: mode, prescale, TOP, compare (never above TOP), output mode, timing
    dspt_row_t rows [9] = '{
        '{4'h8, 3'h1, 16'h0003, 16'h0001, 2'h2, 2, 6, 4'hf},
        '{4'h8, 3'h2, 16'h0003, 16'h0001, 2'h2, 16, 48, 4'hf},
        '{4'h8, 3'h3, 16'h0003, 16'h0001, 2'h2, 128, 384, 4'hf},
        '{4'h8, 3'h4, 16'h0003, 16'h0001, 2'h2, 512, 1536, 4'hf},
        '{4'h8, 3'h5, 16'h0003, 16'h0001, 2'h2, 2048, 6144, 4'hf},
        '{4'h8, 3'h2, 16'h0010, 16'h0004, 2'h2, 64, 256, 4'hf},
        '{4'ha, 3'h2, 16'h0010, 16'h0004, 2'h3, 192, 256, 4'hf},
        '{4'hb, 3'h2, 16'h0010, 16'h0010, 2'h1, 256, 512, 4'h7},
        '{4'h9, 3'h2, 16'h0010, 16'h0010, 2'h1, 256, 512, 4'h7}
    };
    dspt_timer u_dspt_timer (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chan_a_wave_output(wa), .chan_a_wave_oe(oa),
        .chan_b_wave_output(wb), .chan_b_wave_oe(ob), .port_release(port_release)
    );
    dspt_pin_model u_dspt_pin_model (
        .chan_a_wave_output(wa), .chan_a_wave_oe(oa), .chan_b_wave_output(wb),
        .chan_b_wave_oe(ob), .pin_a(pin_a), .pin_b(pin_b)
    );
    // ==========================================
    // Clock and a free-running cycle count, read only after edges settle
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end
    // ==========================================
    // Reporting
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic timeout();
        n_fail++;
        $display("timeout at %0t", $time);
        finish_test();
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_time(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================
    // Avalon master: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= {idx, 2'h0};
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) timeout();
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, idx, wd, dummy);
    endtask
    task automatic rd(input logic [3:0] idx, output logic [31:0] rdata);
        bus(1'b0, idx, 32'h0000_0000, rdata);
    endtask
    // ==========================================
    // Reset, configuration and pin timing helpers
    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        check_val({27'h0, avs_waitrequest, port_release, oa, ob}, 32'h0000_001c);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic setup(input logic [3:0] wave, input logic [2:0] sel, input logic [15:0] top,
                         input logic [15:0] ca, input logic [15:0] cb, input logic [1:0] com);
        do_reset();
        wr(dspt_pkg::IDX_CMP_A, {16'h0, ca});
        wr(dspt_pkg::IDX_CMP_B, {16'h0, cb});
        wr(dspt_pkg::IDX_CAPTURE, {16'h0, top});
        wr(dspt_pkg::IDX_PINDIR, 32'h0000_0003);
        wr(dspt_pkg::IDX_CTRL_A, {24'h0, com, com, 2'h0, wave[1:0]});
        wr(dspt_pkg::IDX_CTRL_B, {27'h0, sel, wave[3:2]});
    endtask
    // Bounded wait for pin A to show a level; n counts the edges waited
    task automatic wait_pin(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pin_a !== lvl && n < 20000);
        if (pin_a !== lvl) timeout();
    endtask
    // ==========================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        n_fail = 0;
        n_checks = 0;
        do_reset();
        for (int i = 0; i < 8; i++) begin
            rd(i[3:0], d);
            check_val(d, 32'h0000_0000);
        end
        wr(dspt_pkg::IDX_CTRL_A, 32'h0000_00ff);
        rd(dspt_pkg::IDX_CTRL_A, d);
        check_val(d, 32'h0000_00f3);
        wr(4'h9, 32'h0000_00ff);
        rd(4'h9, d);
        check_val(d, 32'h0000_0000);
        // Table of waveform cases; the first full wave after start is skipped
        foreach (rows[i]) begin
            setup(rows[i].wave, rows[i].sel, rows[i].top, rows[i].cmp, rows[i].cmp, rows[i].com);
            wait_pin(1'b0, hi);
            wait_pin(1'b1, hi);
            wait_pin(1'b0, hi);
            wait_pin(1'b1, hi);
            wait_pin(1'b0, hi);
            wait_pin(1'b1, lo);
            check_time(hi, rows[i].hi);
            check_time(hi + lo, rows[i].per);
            check_val({30'h0, port_release}, (rows[i].com == 2'h1) ? 32'h2 : 32'h0);
            rd(dspt_pkg::IDX_FLAGS, d);
            check_val({28'h0, d[3:0]}, {28'h0, rows[i].flags});
        end
        // Fixed TOP from capture new compare waits for BOTTOM: old low, mixed high, new low
        setup(4'h8, 3'h2, 16'h0010, 16'h0004, 16'h0004, 2'h2);
        wait_pin(1'b1, hi);
        wait_pin(1'b0, hi);
        wait_pin(1'b1, hi);
        wait_pin(1'b0, hi);
        t0 = cyc;
        wr(dspt_pkg::IDX_CMP_A, 32'h0000_0008);
        wait_pin(1'b1, lo);
        lo = cyc - t0;
        wait_pin(1'b0, hi);
        wait_pin(1'b1, lo2);
        check_time(lo, 192);
        check_time(hi, 96);
        check_time(lo2, 128);
        // Extreme compare values in both dual-slope families
        for (int m = 0; m < 2; m++) begin
            setup(m ? 4'ha : 4'h8, 3'h2, 16'h0010, 16'h0000, 16'h0010, 2'h2);
            repeat (600) @(posedge clk_sys);
            bad = 0;
            repeat (600) begin
                @(posedge clk_sys);
                if (pin_a !== 1'b0 || pin_b !== 1'b1) bad++;
            end
            check_time(bad, 0);
        end
        // Clearing the direction bits hands both pins back to their pull-ups
        wr(dspt_pkg::IDX_PINDIR, 32'h0000_0000);
        repeat (4) @(posedge clk_sys);
        check_val({28'h0, oa, ob, pin_a, pin_b}, 32'h0000_0003);
        // Clock enable low for 20 edges: counter, prescaler and bus all stand still
        setup(4'h8, 3'h1, 16'hffff, 16'h0000, 16'h0000, 2'h2);
        rd(dspt_pkg::IDX_COUNT, d);
        ce <= 1'b0;
        repeat (20) @(posedge clk_sys);
        ce <= 1'b1;
        rd(dspt_pkg::IDX_COUNT, d2);
        check_val(d2 - d, 32'h0000_0003);
        finish_test();
    end
endmodule
`default_nettype wire
